// ===== hdl/wmul_core.sv
// wreg-by-file multiply: decode, file read, multiply, product write over four quarters
// Operation
// - w and file byte are unsigned 8-bit operands multiplied together
// - full 16-bit product goes to high and low product byte registers
// - neither wreg nor the source file register is modified
// - no status flag changes; no carry, overflow or zero signalled
// - access bit 0 reads access bank; 1 uses bank selector register
// - access 0 with extended set and address up to 95 uses indexed offset
// - one word, one cycle: decode, read, process, write in four quarters
`timescale 1ns/1ps
`include "wmul_defines.svh"
module wmul_core
  import wmul_pkg::*;
(
  input  wire logic        clock_in,          // core clock, 100 MHz
  input  wire logic        sys_rst_in,        // synchronous reset, active high
  input  wire logic        instr_valid_in,    // fetched word valid at q1
  input  wire logic [15:0] instr_word_in,     // program word
  input  wire logic        ext_set_en_in,     // extended instruction set enabled
  input  wire logic [3:0]  bank_selector_reg_in, // bank selector register
  input  wire logic [11:0] index_base_in,     // index pointer for indexed offset
  input  wire logic [7:0]  wreg_in,           // working register value
  input  wire logic [7:0]  file_rdata_in,     // file data, valid in q2
  input  wire logic [7:0]  status_in,         // current status flags
  output logic             file_rd_out,       // file read strobe (q2)
  output logic [11:0]      file_addr_out,     // resolved file address
  output logic             file_wr_out,       // file write strobe, never raised
  output logic             wreg_wr_out,       // wreg write strobe, never raised
  output logic             status_wr_out,     // status write strobe, never raised
  output logic [7:0]       status_out,        // status passed back unchanged
  output logic [7:0]       product_high_byte_out, // product high byte
  output logic [7:0]       product_low_byte_out,  // product low byte
  output logic             prod_wr_out,       // product written this cycle
  output logic             busy_out           // instruction in flight
);
  wmul_quarter_t quarter;
  wmul_quarter_t next_quarter;
  wmul_decode_t  dec;
  wmul_decode_t  next_dec;
  logic [7:0]    op_w;
  logic [7:0]    next_op_w;
  logic [7:0]    op_f;
  logic [7:0]    next_op_f;
  wmul_product_t prod;
  wmul_product_t next_prod;
  wmul_product_t mul_res;
  logic          next_file_rd;
  logic [11:0]   next_file_addr;
  logic          next_prod_wr;
  logic          next_busy;
  logic [7:0]    next_status;

  function automatic logic is_multiply(input logic [15:0] w);
    is_multiply = (w[`WMUL_OPC_HI:`WMUL_OPC_LO] == `WMUL_OPC_VAL);
  endfunction : is_multiply

  // resolves the 12-bit data address for an 8-bit operand field
  function automatic logic [11:0] resolve_addr(input logic acc, input logic [7:0] f,
                                               input logic ext, input logic [3:0] bank,
                                               input logic [11:0] base);
    if (acc) begin
      resolve_addr = {bank, f};
    end else if (ext && (f <= `WMUL_ILO_LIMIT)) begin
      resolve_addr = 12'(base + {4'h0, f});
    end else if (f < `WMUL_ACCESS_SPLIT) begin
      resolve_addr = {4'h0, f};
    end else begin
      resolve_addr = {`WMUL_SFR_BANK, f};
    end
  endfunction : resolve_addr

  wmul_multiplier u_mul (
    .a_in     (op_w),
    .b_in     (op_f),
    .prod_out (mul_res)
  );

  always_comb begin
    next_quarter   = quarter;
    next_dec       = dec;
    next_op_w      = op_w;
    next_op_f      = op_f;
    next_prod      = prod;
    next_file_rd   = 1'b0;
    next_file_addr = file_addr_out;
    next_prod_wr   = 1'b0;
    next_busy      = busy_out;
    next_status    = status_in;
    case (quarter)
      WMUL_Q1_DECODE: begin
        if (instr_valid_in && is_multiply(instr_word_in)) begin
          next_dec.valid  = 1'b1;
          next_dec.access = instr_word_in[`WMUL_ACCESS_BIT];
          next_dec.faddr  = instr_word_in[`WMUL_FADDR_HI:0];
          next_file_addr  = resolve_addr(instr_word_in[`WMUL_ACCESS_BIT],
                                         instr_word_in[`WMUL_FADDR_HI:0], ext_set_en_in,
                                         bank_selector_reg_in, index_base_in);
          next_file_rd    = 1'b1;
          next_busy       = 1'b1;
          next_quarter    = WMUL_Q2_READ;
        end
      end
      WMUL_Q2_READ: begin
        next_op_w    = wreg_in;
        next_op_f    = file_rdata_in;
        next_quarter = WMUL_Q3_PROCESS;
      end
      WMUL_Q3_PROCESS: begin
        next_prod    = mul_res;
        next_prod_wr = 1'b1;
        next_quarter = WMUL_Q4_WRITE;
      end
      WMUL_Q4_WRITE: begin
        next_dec.valid = 1'b0;
        next_busy      = 1'b0;
        next_quarter   = WMUL_Q1_DECODE;
      end
      default: begin
        next_quarter = WMUL_Q1_DECODE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      quarter               <= WMUL_Q1_DECODE;
      dec                   <= '0;
      op_w                  <= `WMUL_WREG_RESET;
      op_f                  <= `WMUL_WREG_RESET;
      prod                  <= '{high: `WMUL_PROD_RESET, low: `WMUL_PROD_RESET};
      file_rd_out           <= 1'b0;
      file_addr_out         <= 12'h000;
      prod_wr_out           <= 1'b0;
      busy_out              <= 1'b0;
      status_out            <= 8'h00;
      file_wr_out           <= 1'b0;
      wreg_wr_out           <= 1'b0;
      status_wr_out         <= 1'b0;
      product_high_byte_out <= `WMUL_PROD_RESET;
      product_low_byte_out  <= `WMUL_PROD_RESET;
    end else begin
      quarter               <= next_quarter;
      dec                   <= next_dec;
      op_w                  <= next_op_w;
      op_f                  <= next_op_f;
      prod                  <= next_prod;
      file_rd_out           <= next_file_rd;
      file_addr_out         <= next_file_addr;
      prod_wr_out           <= next_prod_wr;
      busy_out              <= next_busy;
      status_out            <= next_status;
      // operands are only read, never written back
      file_wr_out           <= 1'b0;
      wreg_wr_out           <= 1'b0;
      status_wr_out         <= 1'b0;
      product_high_byte_out <= next_prod.high;
      product_low_byte_out  <= next_prod.low;
    end
  end

  // helper: operands captured for checking the product
  logic [15:0] chk_prod;
  assign chk_prod = {8'h00, op_w} * {8'h00, op_f};

  sequence s_start;
    quarter == WMUL_Q1_DECODE && instr_valid_in && is_multiply(instr_word_in);
  endsequence
  sequence s_walk;
    quarter == WMUL_Q2_READ ##1 quarter == WMUL_Q3_PROCESS ##1 quarter == WMUL_Q4_WRITE
      ##1 quarter == WMUL_Q1_DECODE;
  endsequence

  property p_product;
    @(posedge clock_in) disable iff (sys_rst_in)
    quarter == WMUL_Q3_PROCESS |=> {product_high_byte_out, product_low_byte_out}
      == $past(chk_prod);
  endproperty
  a_product: assert property (p_product) else $error("product mismatch");
  property p_write_pulse;
    @(posedge clock_in) disable iff (sys_rst_in)
    s_start |-> ##3 prod_wr_out ##1 !prod_wr_out;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("product write not in q4");
  property p_no_writeback;
    @(posedge clock_in) disable iff (sys_rst_in)
    busy_out |-> !file_wr_out && !wreg_wr_out;
  endproperty
  a_no_writeback: assert property (p_no_writeback) else $error("operand written");
  // status_out still holds its reset zero for one edge after release
  property p_status;
    @(posedge clock_in) disable iff (sys_rst_in)
    !status_wr_out && ($past(sys_rst_in) || status_out == $past(status_in));
  endproperty
  a_status: assert property (p_status) else $error("status touched");
  property p_banked;
    @(posedge clock_in) disable iff (sys_rst_in)
    s_start and instr_word_in[`WMUL_ACCESS_BIT] |=>
      file_addr_out == {$past(bank_selector_reg_in), $past(instr_word_in[7:0])};
  endproperty
  a_banked: assert property (p_banked) else $error("bank select wrong");
  property p_indexed;
    @(posedge clock_in) disable iff (sys_rst_in)
    s_start and !instr_word_in[`WMUL_ACCESS_BIT] && ext_set_en_in
      && instr_word_in[7:0] <= `WMUL_ILO_LIMIT |=>
      file_addr_out == 12'($past(index_base_in) + {4'h0, $past(instr_word_in[7:0])});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset wrong");
  property p_quarters;
    @(posedge clock_in) disable iff (sys_rst_in)
    s_start |=> s_walk;
  endproperty
  a_quarters: assert property (p_quarters) else $error("quarter order wrong");
  property p_decode;
    @(posedge clock_in) disable iff (sys_rst_in)
    quarter == WMUL_Q1_DECODE && !(instr_valid_in && is_multiply(instr_word_in))
      |=> !busy_out && !file_rd_out;
  endproperty
  a_decode: assert property (p_decode) else $error("non-matching opcode accepted");
endmodule : wmul_core

// ===== hdl/wmul_defines.svh
// offsets, field positions and timing counts for the wreg-by-file multiply datapath
`ifndef WMUL_DEFINES_SVH
`define WMUL_DEFINES_SVH
`define WMUL_OPC_HI          15
`define WMUL_OPC_LO          9
`define WMUL_OPC_VAL         7'h01
`define WMUL_ACCESS_BIT      8
`define WMUL_FADDR_HI        7
`define WMUL_ILO_LIMIT       8'h5F
`define WMUL_ACCESS_SPLIT    8'h80
`define WMUL_SFR_BANK        4'hF
`define WMUL_BANK_RESET      4'h0
`define WMUL_WREG_RESET      8'h00
`define WMUL_PROD_RESET      8'h00
`define WMUL_QUARTERS        2'h3
`endif

// ===== hdl/wmul_pkg.sv
// types for the wreg-by-file multiply datapath
package wmul_pkg;
  typedef enum logic [1:0] {
    WMUL_Q1_DECODE,
    WMUL_Q2_READ,
    WMUL_Q3_PROCESS,
    WMUL_Q4_WRITE
  } wmul_quarter_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } wmul_product_t;

  typedef struct packed {
    logic       valid;
    logic       access;
    logic [7:0] faddr;
  } wmul_decode_t;
endpackage : wmul_pkg

// ===== hdl/wmul_multiplier.sv
// combinational unsigned 8x8 multiplier
`timescale 1ns/1ps
module wmul_multiplier
  import wmul_pkg::*;
(
  input  wire logic [7:0]    a_in,       // wreg operand
  input  wire logic [7:0]    b_in,       // file operand
  output wmul_product_t      prod_out    // full product
);
  logic [15:0] full;
  always_comb begin
    full     = 16'({8'h00, a_in} * {8'h00, b_in});
    prod_out = '{high: full[15:8], low: full[7:0]};
  end
endmodule : wmul_multiplier

// ===== tb/wmul_testbench.sv
// self-checking bench for the wreg-by-file multiply datapath
`timescale 1ns/1ps
module testbench;
  import wmul_pkg::*;
  logic        clock_in, sys_rst_in, instr_valid_in, ext_set_en_in;
  logic [15:0] instr_word_in;
  logic [3:0]  bank_selector_reg_in;
  logic [11:0] index_base_in, file_addr_out;
  logic [7:0]  wreg_in, file_rdata_in, status_in, status_out, prod_hi, prod_lo;
  logic        file_rd_out, file_wr_out, wreg_wr_out, status_wr_out, prod_wr_out, busy_out;
  int          failures = 0;
  int          checked  = 0;

  wmul_core u_wmul_core (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in), .ext_set_en_in(ext_set_en_in),
    .bank_selector_reg_in(bank_selector_reg_in), .index_base_in(index_base_in),
    .wreg_in(wreg_in), .file_rdata_in(file_rdata_in), .status_in(status_in),
    .file_rd_out(file_rd_out), .file_addr_out(file_addr_out), .file_wr_out(file_wr_out),
    .wreg_wr_out(wreg_wr_out), .status_wr_out(status_wr_out), .status_out(status_out),
    .product_high_byte_out(prod_hi), .product_low_byte_out(prod_lo),
    .prod_wr_out(prod_wr_out), .busy_out(busy_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // one instruction; operands held until the product lands
  task automatic run_mul(input logic a, input logic [7:0] f, input logic [7:0] w,
                         input logic [7:0] d, input logic [11:0] addr);
    int n;
    @(posedge clock_in);
    instr_valid_in <= 1'b1;
    instr_word_in  <= {7'h01, a, f};
    wreg_in        <= w;
    file_rdata_in  <= d;
    for (n = 0; n < 8 && file_rd_out !== 1'b1; n++) begin
      @(posedge clock_in);
      #1;
    end
    if (n == 8) begin
      failures++;
      $display("unexpected at %0t: no file read", $time);
      results();
    end
    cmp_val(16'(n), 16'h0001);
    cmp_val({4'h0, file_addr_out}, {4'h0, addr});
    cmp_bit(busy_out, 1'b1);
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    #1;
    cmp_bit(file_rd_out, 1'b0);
    @(posedge clock_in);
    #1;
    cmp_bit(prod_wr_out, 1'b1);
    cmp_val({prod_hi, prod_lo}, 16'(w) * 16'(d));
    cmp_bit(file_wr_out | wreg_wr_out, 1'b0);
    cmp_bit(status_wr_out, 1'b0);
    cmp_val({8'h00, status_out}, {8'h00, status_in});
  endtask : run_mul

  task automatic t_banked;
    run_mul(1'b1, 8'h20, 8'hC4, 8'hB5, 12'h520);
    run_mul(1'b0, 8'h90, 8'hFF, 8'hFF, 12'hF90);
    run_mul(1'b0, 8'h10, 8'h00, 8'h5A, 12'h010);
  endtask : t_banked

  // indexed only below the 0x60 boundary and only with access bit clear
  task automatic t_indexed;
    @(posedge clock_in);
    ext_set_en_in        <= 1'b1;
    index_base_in        <= 12'hFF0;
    bank_selector_reg_in <= 4'h3;
    run_mul(1'b0, 8'h5F, 8'h80, 8'h02, 12'h04F);
    run_mul(1'b0, 8'h60, 8'h01, 8'h01, 12'h060);
    run_mul(1'b1, 8'h30, 8'h0F, 8'h11, 12'h330);
  endtask : t_indexed

  // foreign opcodes and an invalid word start nothing and keep the product
  task automatic t_ignored;
    logic [15:0] words [3] = '{16'h0520, 16'h0000, 16'h0320};
    logic        vals  [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_in);
      instr_valid_in <= vals[i];
      instr_word_in  <= words[i];
      status_in      <= 8'h3C;
      repeat (6) begin
        @(posedge clock_in);
        #1;
        cmp_bit(file_rd_out | busy_out | prod_wr_out, 1'b0);
      end
      cmp_val({prod_hi, prod_lo}, 16'h00FF);
      cmp_val({8'h00, status_out}, 16'h003C);
    end
    instr_valid_in <= 1'b0;
  endtask : t_ignored

  initial begin
    sys_rst_in           = 1'b1;
    instr_valid_in       = 1'b0;
    instr_word_in        = 16'h0000;
    ext_set_en_in        = 1'b0;
    bank_selector_reg_in = 4'h5;
    index_base_in        = 12'h000;
    wreg_in              = 8'h00;
    file_rdata_in        = 8'h00;
    status_in            = 8'hA5;
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_banked();
    t_indexed();
    t_ignored();
    results();
  end
endmodule : testbench
